// File: pkg/psr_pkg.sv
// Constants and carrier types for the parallel/serial-in shift register.
// Assumes a single clock domain; all pin inputs arrive synchronous to clk.
package psr_pkg;

    // Number of cascaded storage stages
    localparam int PSR_STAGES = 8;
    // Least stage count the tap logic can serve (two taps plus last stage)
    localparam int PSR_MIN_STAGES = 3;
    // Taps sit this many stages before the last one
    localparam int PSR_TAP_A_BACK = 2;
    localparam int PSR_TAP_B_BACK = 1;
    // Stage contents after reset
    localparam logic PSR_STAGE_RESET_BIT = 1'h0;
    // Shift clock history after reset: high, so a clock already high is no edge
    localparam logic PSR_SHIFT_CLOCK_RESET = 1'h1;

    // Choice of parallel load behaviour
    typedef enum {
        PSR_LOAD_SYNC,
        PSR_LOAD_ASYNC
    } psr_load_mode_t;

    // Control pins driven by the controlling logic
    typedef struct packed {
        logic shiftClock;
        logic loadSelect;
        logic serialIn;
    } psr_ctrl_t;

    // Outputs read by the controlling logic
    typedef struct packed {
        logic tapStage6;
        logic tapStage7;
        logic serialOut;
    } psr_taps_t;

endpackage : psr_pkg

// File: verilog/psr_clock_edge.sv
// Rising edge detector for the sampled shift clock pin.
// Assumes shiftClock is already synchronous to clk.
`timescale 1ns/10ps
module psr_clock_edge
    import psr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic shiftClock,
    output logic risePulse
);

    // Whole state of this module
    typedef struct packed {
        logic lastLevel;
    } psr_edge_state_t;

    psr_edge_state_t state_r;
    psr_edge_state_t state_nxt;

    // Track the previous clock level
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.lastLevel = shiftClock;
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '{lastLevel: PSR_SHIFT_CLOCK_RESET};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Low then high: one rising transition
    assign risePulse = shiftClock & ~state_r.lastLevel;

    default clocking cbEdge @(posedge clk);
    endclocking
    default disable iff (rst);

    // A pulse never appears twice in a row
    property p_single_pulse;
        risePulse |=> !risePulse;
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("edge pulse lasted two cycles");

endmodule : psr_clock_edge

// File: verilog/psr_shift_register.sv
// Parallel- or serial-in, serial-out shift register with two extra taps.
// Assumes controlling logic drives all pins synchronous to clk and that
// shiftClock is a slow level which this block samples for rising edges.
//
// Function
// - State lives in a cascade of edge-triggered storage stages, eight by default.
// - Last stage drives serial output; the two stages before it drive taps.
// - Load select low: each shift clock rise moves data on, serial bit enters.
// - Synchronous variant: load select high loads parallel inputs at the shift clock rise.
// - Asynchronous variant: load select high loads parallel inputs, no clock rise needed.
// - Asynchronous variant: load select forces the stages without any shift clock edge.
// - Shared clock and load select, one serial input, one parallel input per stage.
`timescale 1ns/10ps
module psr_shift_register
    import psr_pkg::*;
#(
    parameter psr_load_mode_t LOAD_MODE = PSR_LOAD_SYNC,
    parameter int STAGES = PSR_STAGES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire psr_ctrl_t ctrlIn,
    input wire logic [STAGES-1:0] parallelLoadInputs,
    output psr_taps_t tapsOut
);

    // Refuse stage counts that leave no room for the taps
    generate
        if (STAGES < PSR_MIN_STAGES)
        begin : g_bad_stages
            $error("psr_shift_register: STAGES too small for taps");
        end
    endgenerate

    // Refuse a load variant the next-state logic does not decode
    generate
        if (LOAD_MODE != PSR_LOAD_SYNC && LOAD_MODE != PSR_LOAD_ASYNC)
        begin : g_bad_mode
            $error("psr_shift_register: unknown LOAD_MODE");
        end
    endgenerate

    // Index of a stage counted back from the last one
    function automatic int backIndex(input int back);
        backIndex = STAGES - 1 - back;
    endfunction : backIndex

    // Whole state of the register
    typedef struct packed {
        logic [STAGES-1:0] stages;
    } psr_state_t;

    psr_state_t state_r;
    psr_state_t state_nxt;
    logic shiftEdge;
    logic loadNow;

    // Rising edges of the shared shift clock
    psr_clock_edge u_clock_edge (
        .clk(clk),
        .rst(rst),
        .shiftClock(ctrlIn.shiftClock),
        .risePulse(shiftEdge)
    );

    // Load condition differs only by variant
    always_comb
    begin
        if (LOAD_MODE == PSR_LOAD_ASYNC)
        begin
            loadNow = ctrlIn.loadSelect;
        end
        else
        begin
            loadNow = ctrlIn.loadSelect & shiftEdge;
        end
    end

    // Next stage contents: load beats shift, otherwise hold
    always_comb
    begin
        state_nxt = state_r;
        if (loadNow)
        begin
            state_nxt.stages = parallelLoadInputs;
        end
        else if (shiftEdge && !ctrlIn.loadSelect)
        begin
            state_nxt.stages = {state_r.stages[STAGES-2:0], ctrlIn.serialIn};
        end
        else
        begin
            state_nxt.stages = state_r.stages;
        end
    end

    // Stage register, updated on every rising clk edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '{stages: {STAGES{PSR_STAGE_RESET_BIT}}};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Taps and serial output straight from the stages
    assign tapsOut.tapStage6 = state_r.stages[backIndex(PSR_TAP_A_BACK)];
    assign tapsOut.tapStage7 = state_r.stages[backIndex(PSR_TAP_B_BACK)];
    assign tapsOut.serialOut = state_r.stages[STAGES-1];

    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (rst);

    // Shift moves every stage one onward
    property p_shift_onward;
        shiftEdge && !ctrlIn.loadSelect |=> state_r.stages[STAGES-1:1] == $past(state_r.stages[STAGES-2:0]);
    endproperty
    a_shift_onward: assert property (p_shift_onward) else $error("shift did not move stages onward");

    // Serial output follows the tap before it after a shift
    property p_tap_chain;
        shiftEdge && !ctrlIn.loadSelect |=> tapsOut.serialOut == $past(tapsOut.tapStage7);
    endproperty
    a_tap_chain: assert property (p_tap_chain) else $error("serial output did not take tap value");

    // Serial input lands in the first stage
    property p_serial_capture;
        shiftEdge && !ctrlIn.loadSelect |=> state_r.stages[0] == $past(ctrlIn.serialIn);
    endproperty
    a_serial_capture: assert property (p_serial_capture) else $error("serial bit not captured");

    // Without an edge or a load the contents stand, even for long runs
    property p_static_hold;
        !shiftEdge && !loadNow |=> $stable(state_r.stages);
    endproperty
    a_static_hold: assert property (p_static_hold) else $error("stages changed with clock static");

    // Three quiet cycles leave the serial output untouched
    property p_quiet_run;
        (!shiftEdge && !ctrlIn.loadSelect)[*3] |=> tapsOut.serialOut == $past(tapsOut.serialOut, 3);
    endproperty
    a_quiet_run: assert property (p_quiet_run) else $error("output drifted while clock static");

    // A shift clock held high gives one shift only
    property p_one_rise;
        ctrlIn.shiftClock && $past(ctrlIn.shiftClock) |-> !shiftEdge;
    endproperty
    a_one_rise: assert property (p_one_rise) else $error("held shift clock shifted twice");

    // The second tap takes the first tap on a shift
    property p_tap_shift;
        shiftEdge && !ctrlIn.loadSelect |=> tapsOut.tapStage7 == $past(tapsOut.tapStage6);
    endproperty
    a_tap_shift: assert property (p_tap_shift) else $error("second tap did not take first tap");

    // Taps show their own parallel bits after a load
    property p_taps_load;
        loadNow |=> tapsOut.tapStage6 == $past(parallelLoadInputs[backIndex(PSR_TAP_A_BACK)])
            && tapsOut.tapStage7 == $past(parallelLoadInputs[backIndex(PSR_TAP_B_BACK)]);
    endproperty
    a_taps_load: assert property (p_taps_load) else $error("taps missed parallel bits");

    // Each stage takes its own parallel input on a load
    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++)
        begin : g_stage_load
            property p_stage_load;
                loadNow |=> state_r.stages[gi] == $past(parallelLoadInputs[gi]);
            endproperty
            a_stage_load: assert property (p_stage_load) else $error("stage missed its parallel bit");
        end
    endgenerate

    // Variant specific load timing
    generate
        if (LOAD_MODE == PSR_LOAD_SYNC)
        begin : g_sync_checks
            property p_sync_load;
                ctrlIn.loadSelect && shiftEdge |=> state_r.stages == $past(parallelLoadInputs);
            endproperty
            a_sync_load: assert property (p_sync_load) else $error("synchronous load missed");

            property p_sync_needs_edge;
                ctrlIn.loadSelect && !shiftEdge |=> $stable(state_r.stages);
            endproperty
            a_sync_needs_edge: assert property (p_sync_needs_edge) else $error("load without clock rise");

            property p_load_beats_shift;
                ctrlIn.loadSelect && shiftEdge |=> tapsOut.serialOut == $past(parallelLoadInputs[STAGES-1]);
            endproperty
            a_load_beats_shift: assert property (p_load_beats_shift) else $error("shift won over load");
        end
        else
        begin : g_async_checks
            property p_async_load;
                ctrlIn.loadSelect |=> state_r.stages == $past(parallelLoadInputs);
            endproperty
            a_async_load: assert property (p_async_load) else $error("asynchronous load missed");

            property p_async_forced;
                ctrlIn.loadSelect && !ctrlIn.shiftClock ##1 ctrlIn.loadSelect && !ctrlIn.shiftClock
                    |=> state_r.stages == $past(parallelLoadInputs);
            endproperty
            a_async_forced: assert property (p_async_forced) else $error("load needed a clock edge");

            property p_async_shift_after;
                !ctrlIn.loadSelect && shiftEdge |=> state_r.stages[0] == $past(ctrlIn.serialIn);
            endproperty
            a_async_shift_after: assert property (p_async_shift_after) else $error("shift broken");

            property p_async_edge_ignored;
                ctrlIn.loadSelect && shiftEdge |=> tapsOut.serialOut == $past(parallelLoadInputs[STAGES-1]);
            endproperty
            a_async_edge_ignored: assert property (p_async_edge_ignored) else $error("edge disturbed load");
        end
    endgenerate

endmodule : psr_shift_register

// File: testbench/psr_ctrl_model.sv
// Controller model driving shift clock, load select, serial and parallel pins.
// Assumes clk is the system clock; pins change just after its rising edge.
`timescale 1ns/10ps
module psr_ctrl_model
    import psr_pkg::*;
(
    input wire logic clk,
    output psr_ctrl_t ctrl,
    output logic [7:0] par
);
    // Idle pins at time zero
    initial
    begin
        ctrl = '0;
        par = 8'h00;
    end

    // One shift clock rise, held high n cycles
    task automatic shift_bit(input logic b, input int n);
        @(posedge clk);
        ctrl <= '{shiftClock: 1'h1, loadSelect: 1'h0, serialIn: b};
        repeat (n) @(posedge clk);
        ctrl.shiftClock <= 1'h0;
        ctrl.serialIn <= ~b; // Stale bit inverted
    endtask : shift_bit

    // Parallel load, with or without a shift clock rise
    task automatic load(input logic [7:0] p, input logic edg);
        @(posedge clk);
        ctrl <= '{shiftClock: edg, loadSelect: 1'h1, serialIn: 1'h0};
        par <= p;
        @(posedge clk);
        ctrl <= '0;
        par <= ~p; // Stale data inverted
    endtask : load

    // Load select held two cycles, shift clock low, parallel word changing
    task automatic load_follow(input logic [7:0] p1, input logic [7:0] p2);
        @(posedge clk);
        ctrl <= '{shiftClock: 1'h0, loadSelect: 1'h1, serialIn: 1'h0};
        par <= p1;
        @(posedge clk);
        par <= p2;
        @(posedge clk);
        ctrl <= '0;
        par <= ~p2; // Stale data inverted
    endtask : load_follow
endmodule : psr_ctrl_model

// File: testbench/tb.sv
// Testbench: sync-load register chained into an async-load register.
// Assumes the controller model drives both; second serial input is first output.
`timescale 1ns/10ps
module tb
    import psr_pkg::*;
;
    logic clk;
    logic rst;
    psr_ctrl_t ctrl;
    psr_ctrl_t ctrlB;
    logic [7:0] par;
    logic [7:0] expA;
    logic [7:0] expB;
    psr_taps_t tapsA;
    psr_taps_t tapsB;
    int errCount;
    int nTests;

    // Chain: first last stage feeds second serial input
    assign ctrlB = '{shiftClock: ctrl.shiftClock, loadSelect: ctrl.loadSelect, serialIn: tapsA.serialOut};

    psr_ctrl_model psr_ctrl_model_i (.clk(clk), .ctrl(ctrl), .par(par));
    psr_shift_register #(.LOAD_MODE(PSR_LOAD_SYNC), .STAGES(PSR_STAGES)) psr_shift_register_i (
        .clk(clk), .rst(rst), .ctrlIn(ctrl), .parallelLoadInputs(par), .tapsOut(tapsA));
    psr_shift_register #(.LOAD_MODE(PSR_LOAD_ASYNC), .STAGES(PSR_STAGES)) psr_shift_register_async_i (
        .clk(clk), .rst(rst), .ctrlIn(ctrlB), .parallelLoadInputs(par), .tapsOut(tapsB));

    // Expected taps from a stage image
    function automatic psr_taps_t tp(input logic [7:0] e);
        return '{tapStage6: e[5], tapStage7: e[6], serialOut: e[7]};
    endfunction : tp

    // Compare both registers against their images
    task automatic chk(input string nm);
        #1;
        nTests += 2;
        if (tapsA !== tp(expA))
        begin
            errCount++;
            $display("MISMATCH %s sync exp %b got %b", nm, tp(expA), tapsA);
        end
        if (tapsB !== tp(expB))
        begin
            errCount++;
            $display("MISMATCH %s async exp %b got %b", nm, tp(expB), tapsB);
        end
    endtask : chk

    // One shift of both images and pins
    task automatic push(input logic b, input int n);
        expB = {expB[6:0], expA[7]};
        expA = {expA[6:0], b};
        psr_ctrl_model_i.shift_bit(b, n);
    endtask : push

    task automatic t_shift;
        logic [15:0] d;
        d = 16'hb42d;
        for (int i = 15; i >= 0; i--)
        begin
            push(d[i], 1);
            chk("shift");
        end
    endtask : t_shift

    task automatic t_hold;
        repeat (40) @(posedge clk);
        chk("hold");
        push(1'h1, 20);
        repeat (20) @(posedge clk);
        chk("held clock");
    endtask : t_hold

    task automatic t_load;
        psr_ctrl_model_i.load(8'h3c, 1'h1);
        expA = 8'h3c;
        expB = 8'h3c;
        chk("load edge");
        psr_ctrl_model_i.load(8'hc5, 1'h0);
        expB = 8'hc5;
        chk("load no edge");
        for (int i = 0; i < 3; i++)
        begin
            push(1'h0, 1);
            chk("shift loaded");
        end
    endtask : t_load

    task automatic t_follow;
        psr_ctrl_model_i.load_follow(8'h69, 8'h96);
        expB = 8'h96;
        chk("load follows");
        push(1'h1, 1);
        chk("shift after follow");
    endtask : t_follow

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Clock
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // Watchdog
    initial
    begin
        repeat (2000) @(posedge clk);
        errCount++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        rst = 1'h1;
        errCount = 0;
        nTests = 0;
        expA = 8'h00;
        expB = 8'h00;
        repeat (3) @(posedge clk);
        chk("reset");
        @(posedge clk);
        rst <= 1'h0;
        t_shift();
        t_hold();
        t_load();
        t_follow();
        report_and_stop();
    end
endmodule : tb
